//--- rtl/cpf_pkg.sv
// Constants shared by the cell protection state logic.
// Assumes a 200 MHz internal oscillator clock; counts derive from it.
package cpf_pkg;

    // Width of every delay counter
    localparam int CNT_W = 12;

    // Clock period and delay times, each in nanoseconds
    localparam int CLK_NS     = 5;
    localparam int DET_NS     = 10000; // Counter-timed detection delay
    localparam int REL_NS     = 2000;  // Counter-timed release delay
    localparam int SC_NS      = 500;   // Short-circuit delay, never shortened
    localparam int SHORT_DIV  = 64;    // Test mode divides detection and release delays

    // Least times round up to whole cycles
    localparam logic [CNT_W-1:0] DET_CYC =
        CNT_W'((DET_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] REL_CYC =
        CNT_W'((REL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] SC_CYC  =
        CNT_W'((SC_NS + CLK_NS - 1) / CLK_NS);

    // Reset values of the gate drives and resistor switches
    localparam logic CHG_RST = 1'b1;
    localparam logic DIS_RST = 1'b1;
    localparam logic SW_RST  = 1'b0;

    // Bit positions of the comparator vector before synchronising
    localparam int IN_OVC  = 0;
    localparam int IN_OVCR = 1;
    localparam int IN_OVD  = 2;
    localparam int IN_OVI  = 3;
    localparam int IN_SC   = 4;
    localparam int IN_XCH  = 5;
    localparam int IN_STBR = 6;
    localparam int IN_ZC   = 7;
    localparam int IN_ZV   = 8;
    localparam int IN_TEST = 9;
    localparam int IN_W    = 10;

    // Shortened delay for test mode, never below one cycle
    function automatic logic [CNT_W-1:0] cpf_short(
        input logic [CNT_W-1:0] lim);
        logic [CNT_W-1:0] s;
        s = lim / CNT_W'(SHORT_DIV);
        return (s == '0) ? CNT_W'(1) : s;
    endfunction : cpf_short

endpackage : cpf_pkg

//--- rtl/cpf_sync.sv
// Two-stage synchroniser for the comparator and pin inputs.
// Assumes inputs are asynchronous levels; only the second stage is read.
`timescale 1ns/1ps
`default_nettype none
module cpf_sync
    import cpf_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic            i_reset_n,
    input  wire logic [IN_W-1:0] i_async,
    output var  logic [IN_W-1:0] o_sync
);

    logic [IN_W-1:0] meta_q;

    // First stage feeds the second stage and nothing else
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule : cpf_sync
`default_nettype wire

//--- rtl/cpf_delay.sv
// One delay timer: counts while its condition holds.
// Assumes the caller picks the limit; dropping the condition restarts it.
`timescale 1ns/1ps
`default_nettype none
module cpf_delay
    import cpf_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_run,
    input  wire logic [CNT_W-1:0] i_limit,
    output logic                  o_done
);

    logic [CNT_W-1:0] cnt_q;

    // Any gap in the condition clears the count
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cnt_q <= '0;
        end else if (!i_run) begin
            cnt_q <= '0;
        end else if (cnt_q < i_limit) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // Done while the condition still holds after the full count
    assign o_done = i_run && (cnt_q >= i_limit);

endmodule : cpf_delay
`default_nettype wire

//--- rtl/cpf_fsm.sv
// Protection state logic of a two-cell battery guard.
// Assumes analog comparators outside; their levels arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module cpf_fsm
    import cpf_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_ovc_cmp,    // A cell at or above over-charge level
    input  wire logic i_ovc_rel,    // Both cells at or below release level
    input  wire logic i_ovd_cmp,    // A cell at or below over-discharge
    input  wire logic i_ovi_cmp,    // Sense node above over-current level
    input  wire logic i_sc_cmp,     // Sense node above short-circuit level
    input  wire logic i_xch_cmp,    // Sense-to-ground below charger level
    input  wire logic i_stby_rel,   // Charger pulls sense below wake level
    input  wire logic i_zero_cell,  // Cell voltage near zero
    input  wire logic i_zero_ok,    // Supply-to-sense above 0V charge level
    input  wire logic i_test,       // Delay shortening input
    output logic      o_chg_gate,   // Charge gate drive, high enables
    output logic      o_dis_gate,   // Discharge gate drive, high enables
    output logic      o_pd_en,      // Sense node pull-down to ground
    output logic      o_pu_en,      // Sense node pull-up to supply
    output logic      o_standby     // Low-power standby indication
);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisation

    logic [IN_W-1:0] raw;
    logic [IN_W-1:0] syn;

    // Gather the pins so one synchroniser covers them all
    always_comb begin
        raw          = '0;
        raw[IN_OVC]  = i_ovc_cmp;
        raw[IN_OVCR] = i_ovc_rel;
        raw[IN_OVD]  = i_ovd_cmp;
        raw[IN_OVI]  = i_ovi_cmp;
        raw[IN_SC]   = i_sc_cmp;
        raw[IN_XCH]  = i_xch_cmp;
        raw[IN_STBR] = i_stby_rel;
        raw[IN_ZC]   = i_zero_cell;
        raw[IN_ZV]   = i_zero_ok;
        raw[IN_TEST] = i_test;
    end

    // Two flops ahead of any logic
    cpf_sync u_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_async   (raw),
        .o_sync    (syn)
    );

    logic ovc_s;
    logic ovcr_s;
    logic ovd_s;
    logic ovi_s;
    logic sc_s;
    logic xch_s;
    logic stbr_s;
    logic zv_s;
    logic test_s;

    assign ovc_s  = syn[IN_OVC];
    assign ovcr_s = syn[IN_OVCR];
    assign ovd_s  = syn[IN_OVD];
    assign ovi_s  = syn[IN_OVI];
    assign sc_s   = syn[IN_SC];
    assign xch_s  = syn[IN_XCH];
    assign stbr_s = syn[IN_STBR];
    assign zv_s   = syn[IN_ZC] && syn[IN_ZV];

    // Open pin reads low outside, so normal delays apply
    assign test_s = syn[IN_TEST];

    ////////////////////////////////////////////////////////////////////
    // Delay limits

    logic [CNT_W-1:0] det_lim;
    logic [CNT_W-1:0] rel_lim;

    // Detection and release delays shrink in test mode
    assign det_lim = test_s ? cpf_short(DET_CYC) : DET_CYC;
    assign rel_lim = test_s ? cpf_short(REL_CYC) : REL_CYC;

    ////////////////////////////////////////////////////////////////////
    // Protection states

    logic ovc_q;     // Over-charge state
    logic ovd_q;     // Over-discharge state
    logic oc_q;      // Over-current or short-circuit state
    logic xch_q;     // Excessive-charger state
    logic stby_q;    // Standby state

    ////////////////////////////////////////////////////////////////////
    // Detection and release conditions

    logic ovc_run;
    logic ovcr_run;
    logic ovd_run;
    logic ovdr_run;
    logic oc_run;
    logic sc_run;
    logic ocr_run;
    logic xch_run;
    logic xchr_run;

    // Over-charge detection is never blocked by over-current
    assign ovc_run  = ovc_s && !ovc_q;
    assign ovcr_run = ovc_q && ovcr_s && !ovc_s;

    // Over-charge detection pre-empts over-discharge
    assign ovd_run  = ovd_s && !ovd_q && !ovc_run;
    assign ovdr_run = ovd_q && !stby_q && !ovd_s;

    // Over-current waits out over-charge and over-discharge
    assign oc_run   = ovi_s && !oc_q && !ovc_q && !ovd_q;

    // Short-circuit only waits for its own state
    assign sc_run   = sc_s && !oc_q;

    // Release when sense node is back at or below threshold
    assign ocr_run  = oc_q && !ovi_s && !sc_s;

    // Charger check only while discharge path is on
    assign xch_run  = xch_s && !xch_q && o_dis_gate;
    assign xchr_run = xch_q && !xch_s;

    ////////////////////////////////////////////////////////////////////
    // Delay timers

    logic ovc_done;
    logic ovcr_done;
    logic ovd_done;
    logic ovdr_done;
    logic oc_done;
    logic sc_done;
    logic ocr_done;
    logic xch_done;
    logic xchr_done;

    cpf_delay u_ovc (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_run(ovc_run), .i_limit(det_lim), .o_done(ovc_done));
    cpf_delay u_ovcr (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_run(ovcr_run), .i_limit(rel_lim), .o_done(ovcr_done));
    cpf_delay u_ovd (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_run(ovd_run), .i_limit(det_lim), .o_done(ovd_done));
    cpf_delay u_ovdr (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_run(ovdr_run), .i_limit(rel_lim), .o_done(ovdr_done));
    cpf_delay u_oc (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_run(oc_run), .i_limit(det_lim), .o_done(oc_done));
    cpf_delay u_ocr (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_run(ocr_run), .i_limit(rel_lim), .o_done(ocr_done));
    cpf_delay u_xch (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_run(xch_run), .i_limit(det_lim), .o_done(xch_done));
    cpf_delay u_xchr (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_run(xchr_run), .i_limit(rel_lim), .o_done(xchr_done));

    // Fixed short-circuit delay, test input has no say
    cpf_delay u_sc (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_run(sc_run), .i_limit(SC_CYC), .o_done(sc_done));

    ////////////////////////////////////////////////////////////////////
    // State updates

    // Over-charge state
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ovc_q <= 1'b0;
        end else if (ovc_done) begin
            ovc_q <= 1'b1;
        end else if (ovcr_done) begin
            ovc_q <= 1'b0;
        end
    end

    // Over-discharge state, released only after standby ends
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ovd_q <= 1'b0;
        end else if (ovd_done) begin
            ovd_q <= 1'b1;
        end else if (ovdr_done) begin
            ovd_q <= 1'b0;
        end
    end

    // No standby when over-charge came first
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            stby_q <= 1'b0;
        end else if (ovd_done && !ovc_q) begin
            stby_q <= 1'b1;
        end else if (stbr_s) begin
            stby_q <= 1'b0;
        end
    end

    // Over-current or short state
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            oc_q <= 1'b0;
        end else if (oc_done || sc_done) begin
            oc_q <= 1'b1;
        end else if (ocr_done) begin
            oc_q <= 1'b0;
        end
    end

    // Excessive-charger state; a dropped condition just restarts
    // the timer
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            xch_q <= 1'b0;
        end else if (xch_done) begin
            xch_q <= 1'b1;
        end else if (xchr_done) begin
            xch_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output drives, all registered one cycle after the states

    // Charge gate; a zero-volt cell overrides
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_chg_gate <= CHG_RST;
        end else begin
            o_chg_gate <= zv_s || !(ovc_q || xch_q);
        end
    end

    // Discharge gate
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_dis_gate <= DIS_RST;
        end else begin
            o_dis_gate <= !(ovd_q || oc_q);
        end
    end

    // Sense switches; over-discharge swaps pull-down for pull-up,
    // both stay open when only over-charge holds;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_pd_en <= SW_RST;
            o_pu_en <= SW_RST;
        end else begin
            o_pd_en <= oc_q && !ovd_q;
            o_pu_en <= ovd_q;
        end
    end

    // Standby flag out
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_standby <= 1'b0;
        end else begin
            o_standby <= stby_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    property p_oc_pd;
        $rose(oc_q) && !ovd_q |=> o_pd_en && !o_dis_gate;
    endproperty
    a_oc_pd: assert property (p_oc_pd)
        else $error("pull-down not on after over-current");
    property p_oc_rel;
        ocr_done && !ovd_q |=> !oc_q ##1 o_dis_gate;
    endproperty
    a_oc_rel: assert property (p_oc_rel)
        else $error("discharge gate not raised after release");
    property p_xch_cause;
        $rose(xch_q) |-> $past(xch_s) && $past(o_dis_gate);
    endproperty
    a_xch_cause: assert property (p_xch_cause)
        else $error("charger state without held condition");
    property p_xch_gate;
        $rose(xch_q) && !zv_s |=> !o_chg_gate;
    endproperty
    a_xch_gate: assert property (p_xch_gate)
        else $error("charge gate not low on charger detection");
    // Watches the timer itself, so a counter that keeps its count fails
    property p_xch_block;
        !o_dis_gate |=> u_xch.cnt_q == '0;
    endproperty
    a_xch_block: assert property (p_xch_block)
        else $error("charger timer ran while discharge gate low");
    property p_test_lim;
        test_s |-> det_lim == cpf_short(DET_CYC) && det_lim < DET_CYC
            && rel_lim == cpf_short(REL_CYC) && rel_lim < REL_CYC;
    endproperty
    a_test_lim: assert property (p_test_lim)
        else $error("test mode did not shorten delays");
    property p_norm_lim;
        !test_s |-> det_lim == DET_CYC && rel_lim == REL_CYC;
    endproperty
    a_norm_lim: assert property (p_norm_lim)
        else $error("normal delays not applied");
    property p_ovc_pre;
        ovc_run |=> u_ovd.cnt_q == '0;
    endproperty
    a_ovc_pre: assert property (p_ovc_pre)
        else $error("over-discharge counted during over-charge");
    property p_no_stby;
        ovd_done && ovc_q |=> !stby_q ##1 o_pu_en;
    endproperty
    a_no_stby: assert property (p_no_stby)
        else $error("standby entered after over-charge");
    property p_ovc_only;
        ovc_q && !ovd_q && !oc_q |=> !o_pd_en && !o_pu_en;
    endproperty
    a_ovc_only: assert property (p_ovc_only)
        else $error("sense switch closed in over-charge");
    property p_oc_block;
        (ovc_q || ovd_q) |=> u_oc.cnt_q == '0;
    endproperty
    a_oc_block: assert property (p_oc_block)
        else $error("over-current counted while blocked");
    property p_ovd_swap;
        $rose(ovd_q) && $past(oc_q) && !ovc_q |=>
            o_pu_en && !o_pd_en && stby_q;
    endproperty
    a_ovd_swap: assert property (p_ovd_swap)
        else $error("switches not swapped for standby");
    property p_ovc_gate;
        $rose(ovc_q) && !zv_s |=> !o_chg_gate;
    endproperty
    a_ovc_gate: assert property (p_ovc_gate)
        else $error("charge gate not low after over-charge");
    c_ovc:   cover property ($rose(ovc_q));
    c_oc:    cover property ($rose(oc_q) ##[1:1000] $fell(oc_q));
    c_xch:   cover property ($rose(xch_q));
    c_stby:  cover property ($rose(stby_q) && $past(oc_q));

endmodule : cpf_fsm
`default_nettype wire

//--- sim/cpf_fets.sv
// Behavioural model of the board around the guard: the two gate FETs
// and the strap on the delay shortening pin.
// Assumes gate drives arrive as plain levels; conduction follows at once.
`timescale 1ns/1ps
`default_nettype none
module cpf_fets (
    input  wire logic i_chg_gate,
    input  wire logic i_dis_gate,
    input  wire logic i_test_req,
    output logic      o_test_pin,
    output logic      o_chg_path,
    output logic      o_dis_path
);
    ////////////////////////////////////////////////////////////////////
    // Strap held low unless a test run asks for the short delays
    assign o_test_pin = i_test_req ? 1'b1 : 1'b0;

    ////////////////////////////////////////////////////////////////////
    // Charge still flows through the discharge FET's body diode, so only
    // the charge gate decides whether charging is possible
    assign o_chg_path = i_chg_gate;
    assign o_dis_path = i_chg_gate & i_dis_gate;
endmodule : cpf_fets
`default_nettype wire

//--- sim/test_cpf_fsm.sv
// Self-checking bench for the protection state logic.
// Assumes the FET board model beside it; one clock at 200 MHz.
`timescale 1ns/1ps
`default_nettype none
module test_cpf_fsm;
    import cpf_pkg::*;

    localparam int DETN = int'(DET_CYC);
    localparam int RELN = int'(REL_CYC);
    localparam int SCN  = int'(SC_CYC);
    localparam int DS   = DETN / SHORT_DIV;
    localparam int RS   = RELN / SHORT_DIV;
    localparam int CH   = 0;
    localparam int DI   = 1;
    localparam int SB   = 4;

    logic            clk   = 1'b0;
    logic            rst_n = 1'b0;
    logic [IN_W-1:0] pins  = '0;
    logic            chg, dis, pd, pu, stb;
    logic            test_pin, chg_path, dis_path;
    int              err_total   = 0;
    int              checks_done = 0;
    wire  [4:0]      outs = {stb, pu, pd, dis, chg};

    ////////////////////////////////////////////////////////////////////
    // Block under test and its board
    cpf_fsm cpf_fsm_inst (
        .i_clk(clk), .i_reset_n(rst_n),
        .i_ovc_cmp(pins[IN_OVC]), .i_ovc_rel(pins[IN_OVCR]),
        .i_ovd_cmp(pins[IN_OVD]), .i_ovi_cmp(pins[IN_OVI]),
        .i_sc_cmp(pins[IN_SC]), .i_xch_cmp(pins[IN_XCH]),
        .i_stby_rel(pins[IN_STBR]), .i_zero_cell(pins[IN_ZC]),
        .i_zero_ok(pins[IN_ZV]), .i_test(test_pin),
        .o_chg_gate(chg), .o_dis_gate(dis), .o_pd_en(pd),
        .o_pu_en(pu), .o_standby(stb)
    );
    cpf_fets cpf_fets_inst (
        .i_chg_gate(chg), .i_dis_gate(dis), .i_test_req(pins[IN_TEST]),
        .o_test_pin(test_pin), .o_chg_path(chg_path),
        .o_dis_path(dis_path)
    );

    ////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Reset and clear every pin; test strap chosen per scenario
    task automatic rst(input logic t);
        logic [IN_W-1:0] p;
        p = '0;
        p[IN_TEST] = t;
        @(posedge clk);
        rst_n <= 1'b0;
        pins  <= p;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : rst

    task automatic put(input int b, input logic v);
        @(posedge clk);
        pins[b] <= v;
    endtask : put

    // Latency window allows for two sync flops, state and output flops
    task automatic wait_lat(input int idx, input logic val, input int lim,
                            input string what);
        int n;
        n = 0;
        while (outs[idx] !== val && n < lim + 9) begin
            @(negedge clk);
            n++;
        end
        check(what, 1'b1, (n >= lim - 2) && (n <= lim + 8));
    endtask : wait_lat

    // Output must keep its level for n cycles, sampled mid-cycle
    task automatic hold(input int idx, input logic val, input int n,
                        input string what);
        logic seen;
        seen = val;
        repeat (n) begin
            @(negedge clk);
            if (outs[idx] !== val) seen = outs[idx];
        end
        check(what, val, seen);
    endtask : hold

    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        rst(1'b1);
        @(negedge clk);
        check("rst", {1'b0, SW_RST, SW_RST, DIS_RST, CHG_RST}, outs);
        $display("test reset finished");
    endtask : t_reset

    task automatic t_ovc();
        rst(1'b1);
        put(IN_OVC, 1'b1);
        wait_lat(CH, 1'b0, DS, "ovc_det");
        check("sw_open", 2'b00, {pu, pd});
        put(IN_OVI, 1'b1);
        hold(DI, 1'b1, DS + 20, "ovi_blocked");
        put(IN_OVI, 1'b0);
        put(IN_ZC, 1'b1);
        put(IN_ZV, 1'b1);
        wait_lat(CH, 1'b1, 0, "zero_chg");
        check("chg_path", 1'b1, chg_path);
        put(IN_ZC, 1'b0);
        wait_lat(CH, 1'b0, 0, "zero_off");
        put(IN_OVC, 1'b0);
        put(IN_OVCR, 1'b1);
        wait_lat(CH, 1'b1, RS, "ovc_rel");
        $display("test overcharge finished");
    endtask : t_ovc

    task automatic t_xch();
        rst(1'b1);
        put(IN_XCH, 1'b1);
        repeat (DS / 2) @(posedge clk);
        put(IN_XCH, 1'b0);
        hold(CH, 1'b1, DS + 10, "xch_abandon");
        put(IN_XCH, 1'b1);
        wait_lat(CH, 1'b0, DS, "xch_det");
        put(IN_XCH, 1'b0);
        wait_lat(CH, 1'b1, RS, "xch_rel");
        $display("test charger finished");
    endtask : t_xch

    // Over-current in either delay mode, with a restart glitch first
    task automatic t_ovi(input logic t);
        int l;
        int r;
        l = t ? DS : DETN;
        r = t ? RS : RELN;
        rst(t);
        put(IN_OVI, 1'b1);
        repeat (l / 2) @(posedge clk);
        put(IN_OVI, 1'b0);
        repeat (3) @(posedge clk);
        put(IN_OVI, 1'b1);
        wait_lat(DI, 1'b0, l, "ovi_det");
        check("pd_on", 1'b1, pd);
        check("dis_path", 1'b0, dis_path);
        put(IN_XCH, 1'b1);
        hold(CH, 1'b1, l + 20, "xch_blocked");
        put(IN_XCH, 1'b0);
        put(IN_OVC, 1'b1);
        wait_lat(CH, 1'b0, l, "ovc_in_oc");
        put(IN_OVC, 1'b0);
        put(IN_OVCR, 1'b1);
        wait_lat(CH, 1'b1, r, "ovc_rel2");
        put(IN_OVI, 1'b0);
        wait_lat(DI, 1'b1, r, "ovi_rel");
        check("pd_off", 1'b0, pd);
        $display("test overcurrent finished");
    endtask : t_ovi

    // Short circuit keeps its delay whatever the strap, even in overcharge
    task automatic t_sc(input logic t);
        rst(t);
        put(IN_OVC, 1'b1);
        wait_lat(CH, 1'b0, t ? DS : DETN, "ovc_first");
        put(IN_SC, 1'b1);
        wait_lat(DI, 1'b0, SCN, "sc_det");
        check("sc_pd", 1'b1, pd);
        put(IN_SC, 1'b0);
        wait_lat(DI, 1'b1, t ? RS : RELN, "sc_rel");
        $display("test short finished");
    endtask : t_sc

    task automatic t_ovd();
        rst(1'b1);
        put(IN_OVI, 1'b1);
        wait_lat(DI, 1'b0, DS, "oc_first");
        put(IN_OVD, 1'b1);
        put(IN_XCH, 1'b1);
        wait_lat(SB, 1'b1, DS, "ovd_stby");
        check("ovd_sw", 2'b10, {pu, pd});
        put(IN_OVI, 1'b0);
        put(IN_STBR, 1'b1);
        repeat (RS + 10) @(posedge clk);
        hold(SB, 1'b0, 1, "stby_clr");
        put(IN_OVD, 1'b0);
        wait_lat(DI, 1'b1, RS, "ovd_rel");
        check("xch_wait", 1'b1, chg);
        wait_lat(CH, 1'b0, DS, "xch_after");
        $display("test overdischarge finished");
    endtask : t_ovd

    task automatic t_ovc_ovd();
        rst(1'b1);
        @(posedge clk);
        pins <= pins | (IN_W'(1) << IN_OVC) | (IN_W'(1) << IN_OVD);
        wait_lat(CH, 1'b0, DS, "ovc_pref");
        check("ovd_held", 1'b1, dis);
        wait_lat(DI, 1'b0, DS, "ovd_resume");
        check("no_stby", 2'b01, {stb, pu});
        $display("test overlap finished");
    endtask : t_ovc_ovd

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        t_reset();
        t_ovc();
        t_xch();
        t_ovi(1'b1);
        t_ovi(1'b0);
        t_sc(1'b1);
        t_sc(1'b0);
        t_ovd();
        t_ovc_ovd();
        results();
    end

    // Watchdog: all scenarios need well under 15000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        results();
    end
endmodule : test_cpf_fsm
`default_nettype wire
